// *** src/pin_mux_pkg.sv ***
package pin_mux_pkg;

  localparam int LOW_PINS  = 8;
  localparam int HIGH_PINS = 10;

  // Interface modes selected by the configuration
  typedef enum logic [3:0] {
    MODE_ASYNC_SERIAL = 4'h0,
    MODE_SYNC_FIFO    = 4'h1,
    MODE_ASYNC_FIFO   = 4'h2,
    MODE_ASYNC_BANG   = 4'h3,
    MODE_SYNC_BANG    = 4'h4,
    MODE_SERIAL_ENG   = 4'h5,
    MODE_FAST_SERIAL  = 4'h6,
    MODE_CPU_FIFO     = 4'h7,
    MODE_HALF_DUPLEX  = 4'h8
  } mode_t;

  // High-group option codes held in configuration memory
  typedef enum logic [3:0] {
    HOPT_PULLUP_IN = 4'h0,
    HOPT_DRIVE0    = 4'h1,
    HOPT_DRIVE1    = 4'h2,
    HOPT_ENGINE    = 4'h3
  } high_opt_t;

  // Pull codes reported per pin
  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_UP   = 2'h1,
    PULL_DOWN = 2'h2
  } pull_t;

  // Low-group pin positions in the default serial configuration, and high-group pin 7
  localparam int LP_TXD = 0;
  localparam int LP_RXD = 1;
  localparam int LP_RTS = 2;
  localparam int LP_CTS = 3;
  localparam int LP_DTR = 4;
  localparam int LP_DSR = 5;
  localparam int LP_DCD = 6;
  localparam int LP_RI  = 7;
  localparam int HP_GP7 = 7;

  // Output directions of the low group in serial mode: pins 0, 2, 4
  localparam logic [LOW_PINS-1:0] SERIAL_LOW_OE = 8'h15;

  // Low-group pins that may drive in fast serial mode: pins 0 to 3
  localparam logic [LOW_PINS-1:0] FAST_LOW_MASK = 8'h0f;

  // Pin drive bundle for one group
  typedef struct packed {
    logic [HIGH_PINS-1:0]   out;
    logic [HIGH_PINS-1:0]   oe;
    logic [2*HIGH_PINS-1:0] pull;
  } high_drive_t;

  typedef struct packed {
    logic [LOW_PINS-1:0]   out;
    logic [LOW_PINS-1:0]   oe;
    logic [2*LOW_PINS-1:0] pull;
  } low_drive_t;

  // Configuration memory options as loaded
  typedef struct packed {
    logic                   present;
    logic                   remote_wake_en;
    logic                   power_save_en;
    logic                   self_powered;
    logic                   bus_sense_en;
    logic [4*HIGH_PINS-1:0] high_opt;
  } cfg_t;

  // Engine-side signals of the active mode
  typedef struct packed {
    logic [LOW_PINS-1:0]  low_out;
    logic [LOW_PINS-1:0]  low_oe;
    logic [HIGH_PINS-1:0] high_out;
    logic [HIGH_PINS-1:0] high_oe;
  } engine_t;

  localparam logic RESET_CFGCLK = 1'b0;

endpackage

// *** src/multimode_pin_function_mux.sv ***
`timescale 1ns/1ps
`default_nettype none

module multimode_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   clk_en_i,
  input  wire mode_t                  mode_sel_i,
  input  wire logic                   mode_sel_valid_i,
  input  wire cfg_t                   cfg_i,
  input  wire engine_t                engine_i,
  input  wire logic                   serial_txd_i,
  input  wire logic                   serial_rts_n_i,
  input  wire logic                   serial_dtr_n_i,
  input  wire logic                   suspended_i,
  input  wire logic                   cfgmem_select_drv_i,
  input  wire logic                   cfgmem_clock_drv_i,
  input  wire logic                   cfgmem_data_drv_i,
  input  wire logic                   cfgmem_data_oe_i,
  input  wire logic [LOW_PINS-1:0]    low_io_group_i,
  input  wire logic [HIGH_PINS-1:0]   high_io_group_i,
  input  wire logic                   power_save_n_i,
  output logic [LOW_PINS-1:0]         low_io_group_o,
  output logic [LOW_PINS-1:0]         low_io_group_oe_o,
  output logic [2*LOW_PINS-1:0]       low_pull_o,
  output logic [HIGH_PINS-1:0]        high_io_group_o,
  output logic [HIGH_PINS-1:0]        high_io_group_oe_o,
  output logic [2*HIGH_PINS-1:0]      high_pull_o,
  output logic                        serial_rxd_o,
  output logic                        serial_cts_n_o,
  output logic                        serial_dsr_n_o,
  output logic                        carrier_detect_n_o,
  output logic                        ring_indicator_n_o,
  output logic                        bus_voltage_sense_o,
  output mode_t                       active_mode_o,
  output logic                        force_suspend_o,
  output logic                        resume_request_o,
  output logic                        cfgmem_select_o,
  output logic                        cfgmem_select_oe_o,
  output logic                        cfgmem_clock_o,
  output logic                        cfgmem_clock_oe_o,
  output logic                        cfgmem_data_o,
  output logic                        cfgmem_data_oe_o
);

  typedef struct packed {
    mode_t       mode;
    low_drive_t  low;
    high_drive_t high;
    logic        rxd;
    logic        cts_n;
    logic        dsr_n;
    logic        dcd_n;
    logic        ri_n;
    logic        vsense;
    logic        suspend;
    logic        resume;
    logic        cfg_sel;
    logic        cfg_sel_oe;
    logic        cfg_clk;
    logic        cfg_clk_oe;
    logic        cfg_dat;
    logic        cfg_dat_oe;
  } state_t;

  state_t st;
  state_t next_st;

  // Per-pin pulls depend only on each pin's output enable and, for high pin 7, bus_sense_en; one loop per group builds them
  logic [2*LOW_PINS-1:0]  low_pull_c;
  logic [2*HIGH_PINS-1:0] high_pull_c;
  logic [LOW_PINS-1:0]    low_oe_c;
  logic [HIGH_PINS-1:0]   high_oe_c;

  genvar g;
  generate
    for (g = 0; g < HIGH_PINS; g++) begin : g_high
      always_comb begin
        if (g == HP_GP7 && !cfg_i.bus_sense_en && !high_oe_c[g]) begin
          high_pull_c[2*g +: 2] = PULL_DOWN;
        end else if (high_oe_c[g] || (g == HP_GP7 && cfg_i.bus_sense_en)) begin
          high_pull_c[2*g +: 2] = PULL_NONE;
        end else begin
          high_pull_c[2*g +: 2] = PULL_UP;
        end
      end
    end
    for (g = 0; g < LOW_PINS; g++) begin : g_low
      always_comb begin
        low_pull_c[2*g +: 2] = low_oe_c[g] ? PULL_NONE : PULL_UP;
      end
    end
  endgenerate

  logic [3:0] opt;
  logic       ps_active;
  mode_t      mode_c;

  always_comb begin
    next_st  = st;
    mode_c   = mode_sel_valid_i ? mode_sel_i : st.mode;
    low_oe_c = '0;
    high_oe_c = '0;
    next_st.low.out  = '0;
    next_st.high.out = '0;
    opt = '0;

    unique case (mode_c)
      MODE_ASYNC_SERIAL: begin
        low_oe_c = SERIAL_LOW_OE;
        next_st.low.out[LP_TXD] = serial_txd_i;
        next_st.low.out[LP_RTS] = serial_rts_n_i;
        next_st.low.out[LP_DTR] = serial_dtr_n_i;
      end
      MODE_FAST_SERIAL: begin
        // Only the four serial lines are used; the upper four stay pulled-up inputs
        low_oe_c = engine_i.low_oe & FAST_LOW_MASK;
        next_st.low.out = engine_i.low_out & FAST_LOW_MASK;
      end
      default: begin
        low_oe_c = engine_i.low_oe;
        next_st.low.out = engine_i.low_out;
      end
    endcase

    for (int i = 0; i < HIGH_PINS; i++) begin
      opt = cfg_i.present ? cfg_i.high_opt[4*i +: 4] : 4'(HOPT_PULLUP_IN);
      if (i == HP_GP7) begin
        high_oe_c[i] = (mode_c == MODE_SERIAL_ENG) && !cfg_i.bus_sense_en && engine_i.high_oe[i];
        next_st.high.out[i] = engine_i.high_out[i];
      end else if (mode_c != MODE_ASYNC_SERIAL) begin
        high_oe_c[i] = engine_i.high_oe[i];
        next_st.high.out[i] = engine_i.high_out[i];
      end else if (opt == 4'(HOPT_DRIVE0)) begin
        high_oe_c[i] = 1'b1;
        next_st.high.out[i] = 1'b0;
      end else if (opt == 4'(HOPT_DRIVE1)) begin
        high_oe_c[i] = 1'b1;
        next_st.high.out[i] = 1'b1;
      end else if (opt == 4'(HOPT_ENGINE)) begin
        high_oe_c[i] = engine_i.high_oe[i];
        next_st.high.out[i] = engine_i.high_out[i];
      end
    end

    // Everything pin-facing changes in this one registered update
    next_st.mode     = mode_c;
    next_st.low.oe   = low_oe_c;
    next_st.low.pull = low_pull_c;
    next_st.high.oe  = high_oe_c;
    next_st.high.pull = high_pull_c;
    next_st.low.out  = next_st.low.out & low_oe_c;
    next_st.high.out = next_st.high.out & high_oe_c;

    next_st.rxd   = (mode_c == MODE_ASYNC_SERIAL) ? low_io_group_i[LP_RXD] : 1'b1;
    next_st.cts_n = (mode_c == MODE_ASYNC_SERIAL) ? low_io_group_i[LP_CTS] : 1'b1;
    next_st.dsr_n = (mode_c == MODE_ASYNC_SERIAL) ? low_io_group_i[LP_DSR] : 1'b1;
    next_st.dcd_n = (mode_c == MODE_ASYNC_SERIAL) ? low_io_group_i[LP_DCD] : 1'b1;
    next_st.ri_n  = (mode_c == MODE_ASYNC_SERIAL) ? low_io_group_i[LP_RI]  : 1'b1;
    next_st.vsense = cfg_i.bus_sense_en & high_io_group_i[HP_GP7];

    // Board holds the input high while bus power is present
    ps_active = cfg_i.power_save_en && cfg_i.self_powered;
    next_st.suspend = ps_active && !power_save_n_i;
    next_st.resume = cfg_i.remote_wake_en && (suspended_i || next_st.suspend)
                     && (mode_c == MODE_ASYNC_SERIAL) && !low_io_group_i[LP_RI];

    next_st.cfg_sel    = cfgmem_select_drv_i;
    next_st.cfg_sel_oe = 1'b1;
    next_st.cfg_clk    = cfgmem_clock_drv_i;
    next_st.cfg_clk_oe = 1'b1;
    next_st.cfg_dat    = cfgmem_data_drv_i & cfgmem_data_oe_i;
    next_st.cfg_dat_oe = cfgmem_data_oe_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st            <= '0;
      st.mode       <= MODE_ASYNC_SERIAL;
      st.low.pull   <= {LOW_PINS{PULL_UP}};
      st.high.pull  <= {{(HIGH_PINS-HP_GP7-1){PULL_UP}}, PULL_DOWN, {HP_GP7{PULL_UP}}};
      st.rxd        <= 1'b1;
      st.cts_n      <= 1'b1;
      st.dsr_n      <= 1'b1;
      st.dcd_n      <= 1'b1;
      st.ri_n       <= 1'b1;
      st.cfg_clk    <= RESET_CFGCLK;
      st.cfg_sel_oe <= 1'b0;
      st.cfg_clk_oe <= 1'b0;
      st.cfg_dat_oe <= 1'b0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign low_io_group_o      = st.low.out;
  assign low_io_group_oe_o   = st.low.oe;
  assign low_pull_o          = st.low.pull;
  assign high_io_group_o     = st.high.out;
  assign high_io_group_oe_o  = st.high.oe;
  assign high_pull_o         = st.high.pull;
  assign serial_rxd_o        = st.rxd;
  assign serial_cts_n_o      = st.cts_n;
  assign serial_dsr_n_o      = st.dsr_n;
  assign carrier_detect_n_o  = st.dcd_n;
  assign ring_indicator_n_o  = st.ri_n;
  assign bus_voltage_sense_o = st.vsense;
  assign active_mode_o       = st.mode;
  assign force_suspend_o     = st.suspend;
  assign resume_request_o    = st.resume;
  assign cfgmem_select_o     = st.cfg_sel;
  assign cfgmem_select_oe_o  = st.cfg_sel_oe;
  assign cfgmem_clock_o      = st.cfg_clk;
  assign cfgmem_clock_oe_o   = st.cfg_clk_oe;
  assign cfgmem_data_o       = st.cfg_dat;
  assign cfgmem_data_oe_o    = st.cfg_dat_oe;

endmodule

`default_nettype wire

// *** test/pin_mux_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_mux_props
  import pin_mux_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   rst_i,
  input wire logic                   clk_en_i,
  input wire mode_t                  mode_sel_i,
  input wire logic                   mode_sel_valid_i,
  input wire cfg_t                   cfg_i,
  input wire logic                   suspended_i,
  input wire logic [LOW_PINS-1:0]    low_io_group_i,
  input wire logic                   power_save_n_i,
  input wire logic [LOW_PINS-1:0]    low_io_group_oe_o,
  input wire logic [2*HIGH_PINS-1:0] high_pull_o,
  input wire mode_t                  active_mode_o,
  input wire logic                   force_suspend_o,
  input wire logic                   resume_request_o,
  input wire logic                   cfgmem_select_oe_o,
  input wire logic                   cfgmem_clock_oe_o,
  input wire logic                   cfgmem_data_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence release_s;
    rst_i ##1 !rst_i;
  endsequence
  mode_take_a: assert property (clk_en_i && mode_sel_valid_i |=> active_mode_o == $past(mode_sel_i))
    else $error("requested mode not taken");
  freeze_a: assert property (!clk_en_i |=> $stable({active_mode_o, low_io_group_oe_o, force_suspend_o}))
    else $error("state moved while disabled");
  serial_dir_a: assert property (clk_en_i && mode_sel_valid_i && mode_sel_i == MODE_ASYNC_SERIAL
    |=> low_io_group_oe_o == SERIAL_LOW_OE) else $error("serial pin directions wrong");
  save_pin_a: assert property (clk_en_i && cfg_i.power_save_en && cfg_i.self_powered
    |=> force_suspend_o == !$past(power_save_n_i)) else $error("power save not followed");
  bus_pow_a: assert property (clk_en_i && !cfg_i.self_powered |=> !force_suspend_o)
    else $error("suspend forced while bus powered");
  wake_a: assert property (clk_en_i && !mode_sel_valid_i && active_mode_o == MODE_ASYNC_SERIAL
    && cfg_i.remote_wake_en && suspended_i && !low_io_group_i[LP_RI] |=> resume_request_o)
    else $error("no resume request");
  cfg_tri_a: assert property (disable iff (1'b0) rst_i
    |=> !(cfgmem_select_oe_o || cfgmem_clock_oe_o || cfgmem_data_oe_o)) else $error("cfgmem driven in reset");
  cfg_clk_a: assert property (clk_en_i |=> cfgmem_clock_oe_o)
    else $error("cfgmem clock not driven");
  reset_state_a: assert property (disable iff (1'b0) release_s |-> active_mode_o == MODE_ASYNC_SERIAL
    && high_pull_o[2*HP_GP7+:2] == PULL_DOWN) else $error("reset state wrong");
  gp7_pull_a: assert property (high_pull_o[2*HP_GP7+:2] != PULL_UP)
    else $error("high pin 7 pulled up");
endmodule
bind multimode_pin_function_mux pin_mux_props i_props (.*);
`default_nettype wire

// *** test/board_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin_mux_pkg::*;
(
  input  wire logic [LOW_PINS-1:0]  low_out_i,
  input  wire logic [LOW_PINS-1:0]  low_oe_i,
  input  wire logic [LOW_PINS-1:0]  ext_low_i,
  input  wire logic [HIGH_PINS-1:0] high_out_i,
  input  wire logic [HIGH_PINS-1:0] high_oe_i,
  input  wire logic [HIGH_PINS-1:0] ext_high_i,
  input  wire logic                 bus_power_i,
  output logic [LOW_PINS-1:0]       low_pin_o,
  output logic [HIGH_PINS-1:0]      high_pin_o,
  output logic                      power_save_n_o
);
  // Board drives every pin the device has released, so no pin floats
  assign low_pin_o      = (low_oe_i & low_out_i) | (~low_oe_i & ext_low_i);
  assign high_pin_o     = (high_oe_i & high_out_i) | (~high_oe_i & ext_high_i);
  assign power_save_n_o = bus_power_i;
endmodule
`default_nettype wire

// *** test/multimode_pin_function_mux_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module multimode_pin_function_mux_bench;
  import pin_mux_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, valid = 1'b0, txd = 1'b0, susp = 1'b0, bus_power = 1'b1;
  logic cclk_drv = 1'b1;
  logic cclk, cts_n, dsr_n, dcd_n, ri_n;
  mode_t mode = MODE_ASYNC_SERIAL;
  cfg_t cfg = '0;
  engine_t eng = '0;
  logic [7:0] ext_low = 8'hff, low_pin, low_o, low_oe;
  logic [9:0] ext_high = 10'h3ff, high_pin, high_o, high_oe;
  logic [15:0] low_pull;
  logic [19:0] high_pull;
  logic psave_n, rxd, bvs, fsusp, resume, csel_oe, cclk_oe, cdat_oe;
  mode_t mode_o;
  int err_total = 0, n_compared = 0, cycles = 0;

  board_model i_board (.low_out_i(low_o), .low_oe_i(low_oe), .ext_low_i(ext_low), .high_out_i(high_o),
    .high_oe_i(high_oe), .ext_high_i(ext_high), .bus_power_i(bus_power), .low_pin_o(low_pin),
    .high_pin_o(high_pin), .power_save_n_o(psave_n));
  multimode_pin_function_mux i_dut (.clk_sys_i(clk), .rst_i(rst), .clk_en_i(clk_en), .mode_sel_i(mode),
    .mode_sel_valid_i(valid), .cfg_i(cfg), .engine_i(eng), .serial_txd_i(txd), .serial_rts_n_i(1'b1),
    .serial_dtr_n_i(1'b0), .suspended_i(susp), .cfgmem_select_drv_i(1'b1), .cfgmem_clock_drv_i(cclk_drv),
    .cfgmem_data_drv_i(1'b0), .cfgmem_data_oe_i(1'b0), .low_io_group_i(low_pin), .high_io_group_i(high_pin),
    .power_save_n_i(psave_n), .low_io_group_o(low_o), .low_io_group_oe_o(low_oe), .low_pull_o(low_pull),
    .high_io_group_o(high_o), .high_io_group_oe_o(high_oe), .high_pull_o(high_pull), .serial_rxd_o(rxd),
    .serial_cts_n_o(cts_n), .serial_dsr_n_o(dsr_n), .carrier_detect_n_o(dcd_n), .ring_indicator_n_o(ri_n),
    .bus_voltage_sense_o(bvs), .active_mode_o(mode_o), .force_suspend_o(fsusp), .resume_request_o(resume),
    .cfgmem_select_o(), .cfgmem_select_oe_o(csel_oe), .cfgmem_clock_o(cclk), .cfgmem_clock_oe_o(cclk_oe),
    .cfgmem_data_o(), .cfgmem_data_oe_o(cdat_oe));

  always #5 clk = ~clk;
  // Whole run needs well under 100 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      test_done();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    step(5);
    check("cfgmem oe", {csel_oe, cclk_oe, cdat_oe}, 0);
    check("low pull", low_pull, 32'h5555);
    check("high pull", high_pull, 32'h59555);
    check("cfg clock", cclk, 0);
    rst = 1'b0;
    // Alternating levels leave only the carrier detect input high; CTS, DSR and RI all read low
    ext_low = 8'h55;
    txd = 1'b1;
    step(1);
    check("mode", mode_o, MODE_ASYNC_SERIAL);
    check("low oe", low_oe, SERIAL_LOW_OE);
    check("txd", low_o[LP_TXD], 1);
    check("low out", low_o, 8'h05);
    check("rxd", rxd, 0);
    check("modem in", {cts_n, dsr_n, dcd_n, ri_n}, 4'b0010);
    check("cfg clock oe", cclk_oe, 1);
    check("cfg clock", {cclk_oe, cclk}, 2'b11);
    check("high idle", {high_oe, high_pull}, 32'h59555);
    cfg.present = 1'b1;
    cfg.high_opt[3:0] = HOPT_DRIVE1;
    cfg.bus_sense_en = 1'b1;
    ext_high = 10'h080;
    step(1);
    check("high drive", {high_oe[0], high_o[0]}, 2'b11);
    check("bus sense", bvs, 1);
    cfg.remote_wake_en = 1'b1;
    susp = 1'b1;
    ext_low = 8'h7f;
    step(1);
    check("resume", resume, 1);
    check("ring in", ri_n, 0);
    ext_low = 8'hff;
    step(1);
    check("resume", resume, 0);
    susp = 1'b0;
    cfg.power_save_en = 1'b1;
    cfg.self_powered = 1'b1;
    bus_power = 1'b0;
    step(1);
    check("suspend", fsusp, 1);
    bus_power = 1'b1;
    step(1);
    check("suspend", fsusp, 0);
    cfg.self_powered = 1'b0;
    bus_power = 1'b0;
    step(1);
    check("suspend", fsusp, 0);
    bus_power = 1'b1;
    eng.low_oe = 8'hff;
    valid = 1'b1;
    for (int m = 1; m < 9; m++) begin
      mode = mode_t'(m);
      step(1);
      check("mode", mode_o, m);
      check("low oe", {rxd, low_oe}, {1'b1, (mode == MODE_FAST_SERIAL) ? 8'h0f : 8'hff});
    end
    clk_en = 1'b0;
    mode = MODE_ASYNC_SERIAL;
    step(2);
    check("frozen", mode_o, MODE_HALF_DUPLEX);
    clk_en = 1'b1;
    step(1);
    check("low oe", low_oe, SERIAL_LOW_OE);
    mode = MODE_CPU_FIFO;
    step(1);
    check("mode", mode_o, MODE_CPU_FIFO);
    // No mode request across the reset, so the default must come from reset itself
    valid = 1'b0;
    rst = 1'b1;
    step(1);
    check("cfgmem oe", {csel_oe, cclk_oe, cdat_oe}, 0);
    rst = 1'b0;
    step(1);
    check("mode", mode_o, MODE_ASYNC_SERIAL);
    test_done();
  end
endmodule
`default_nettype wire
